// >>> hdl/switch_ctrl_consts.vh
/*
 * timing counts, codes and reset values for the isolated switch enable
 * and burst controller; assumes a 20 MHz clock.
 */
`ifndef SWITCH_CTRL_CONSTS_VH
`define SWITCH_CTRL_CONSTS_VH

`define CLK_PERIOD_NS 50
`define BURST_PERIOD_NS 25000
`define BURST_PERIOD_CYC (`BURST_PERIOD_NS / `CLK_PERIOD_NS)
`define BURST_STEPS 15
`define BURST_STEP_CYC (`BURST_PERIOD_CYC / `BURST_STEPS)
`define ONESHOT_HIGH_TIME_NS 2500
`define ONESHOT_HIGH_CYC (`ONESHOT_HIGH_TIME_NS / `CLK_PERIOD_NS)
`define TWO_WIRE_ON_NS 3300
`define TWO_WIRE_ON_CYC (`TWO_WIRE_ON_NS / `CLK_PERIOD_NS)
`define LEVEL_MIN 3'h1
`define LEVEL_MAX 3'h7
`define CARRIER_DIV_MIN 4'h4
`define CARRIER_DIV_MAX 4'hB
`define LFSR_SEED 8'hA5
`define RX_HOLD_CYC 8'h18

`endif

// >>> hdl/carrier_gen.v
/*
 * spread-spectrum carrier source: a toggling carrier whose half period
 * is drawn from an lfsr each half cycle.
 * assumes a free-running clk and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "switch_ctrl_consts.vh"

module carrier_gen (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // carrier
    output reg carrier_q
);

reg [7:0] lfsr_q;
reg [3:0] cnt_q;
wire [3:0] span;

// half period spread between min+1 and min+8 cycles
assign span = `CARRIER_DIV_MIN + {1'b0, lfsr_q[2:0]};

always @(posedge clk)
begin
    if (!rst_n)
    begin
        lfsr_q <= `LFSR_SEED;
        cnt_q <= 4'h0;
        carrier_q <= 1'b0;
    end
    else if (cnt_q >= span)
    begin
        cnt_q <= 4'h0;
        carrier_q <= ~carrier_q;
        lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
    else
    begin
        cnt_q <= cnt_q + 4'h1;
    end
end

endmodule
`default_nettype wire

// >>> hdl/switch_ctrl.v
/*
 * enable and burst power controller of an isolated switch driver:
 * mode and level capture at power-up, burst scheduling, enable
 * transmission over a modulated carrier and gate drive decision.
 * assumes rst_n is the primary supply power-on reset, and that the
 * analog side provides rail-good and undervoltage levels.
 */
`timescale 1ns/1ps
`default_nettype none
`include "switch_ctrl_consts.vh"

//
// Behaviour
// - three-wire: power flows whenever primary present
// - two-wire: enable starts power, drive after rails
// - two-wire: enable low kills drive and power
// - three-wire steady: drive follows enable
// - standard variant: drive tracks enable unshaped
// - one-shot (three-wire only): edge gives short pulse
// - one-shot retrigger needs enable low then high
// - three-wire bursts of 25 us period
// - fixed period, on-time set by level
// - level n gives n*2/15 duty cycle
// - enable modulated on carrier, demodulated to drive
// - carrier frequency spread over a range
// - one-shot pulse lasts 2.5 us
// - level captured at power-up, then held
// - rail undervoltage forces drive low
// - wire mode chosen at power-up, then held
module switch_ctrl (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // host side
    input wire switch_enable,
    input wire oneshot_select,
    input wire three_wire_detect,
    input wire [2:0] power_level_select,
    // isolated side status
    input wire rails_ready,
    input wire rails_uvlo,
    // outputs
    output reg power_xfer_q,
    output reg tx_data_q,
    output reg gate_drive_q,
    output reg three_wire_q,
    output reg [2:0] level_q
);

localparam ST_CAPTURE = 2'h0;
localparam ST_RUN = 2'h1;

reg [1:0] state_q;
reg en_s1_q, en_s2_q, en_prev_q;
reg rdy_s1_q, rdy_s2_q, uv_s1_q, uv_s2_q;
reg tw_s1_q, tw_s2_q, os_s1_q, os_s2_q;
reg [2:0] lv_s1_q, lv_s2_q;
reg oneshot_q;
reg armed_q;
reg [9:0] burst_cnt_q;
reg [5:0] pulse_cnt_q;
reg [7:0] rx_cnt_q;
reg rx_en_q;
wire carrier;
wire [9:0] on_cyc;
wire [31:0] on_full;
wire [31:0] pulse_len;
wire enable_rise;
reg drive_d;

// invalid codes map to the lowest setting
function [2:0] level_fix;
    input [2:0] code;
    begin
        if (code < `LEVEL_MIN || code > `LEVEL_MAX)
            level_fix = `LEVEL_MIN;
        else
            level_fix = code;
    end
endfunction

carrier_gen u_carrier (
    .clk(clk),
    .rst_n(rst_n),
    .carrier_q(carrier)
);

// two-flop synchronisers for every pin level; they run through reset so
// the straps are already settled on the capture edge
always @(posedge clk)
begin
    en_s1_q <= switch_enable;
    en_s2_q <= en_s1_q;
    rdy_s1_q <= rails_ready;
    rdy_s2_q <= rdy_s1_q;
    uv_s1_q <= rails_uvlo;
    uv_s2_q <= uv_s1_q;
    tw_s1_q <= three_wire_detect;
    tw_s2_q <= tw_s1_q;
    os_s1_q <= oneshot_select;
    os_s2_q <= os_s1_q;
    lv_s1_q <= power_level_select;
    lv_s2_q <= lv_s1_q;
end

assign enable_rise = en_s2_q & ~en_prev_q;
// on-time = level * 2 steps of period/15, at most 462 cycles
assign on_full = level_q * (`BURST_STEP_CYC * 2);
assign on_cyc = on_full[9:0];
assign pulse_len = `ONESHOT_HIGH_CYC;

// capture mode and level once after release, hold until power cycle
always @(posedge clk)
begin
    if (!rst_n)
    begin
        state_q <= ST_CAPTURE;
        three_wire_q <= 1'b0;
        level_q <= `LEVEL_MIN;
        oneshot_q <= 1'b0;
    end
    else
    begin
        case (state_q)
            ST_CAPTURE:
            begin
                three_wire_q <= tw_s2_q;
                level_q <= level_fix(lv_s2_q);
                oneshot_q <= os_s2_q & tw_s2_q;
                state_q <= ST_RUN;
            end
            ST_RUN:
            begin
                state_q <= ST_RUN;
            end
            default:
            begin
                state_q <= ST_CAPTURE;
            end
        endcase
    end
end

// burst scheduler
always @(posedge clk)
begin
    if (!rst_n || state_q != ST_RUN)
    begin
        burst_cnt_q <= 10'h000;
        power_xfer_q <= 1'b0;
    end
    else if (three_wire_q)
    begin
        // constant period, level-dependent on-time, independent of enable
        if (burst_cnt_q == `BURST_PERIOD_CYC - 1)
            burst_cnt_q <= 10'h000;
        else
            burst_cnt_q <= burst_cnt_q + 10'h001;
        power_xfer_q <= (burst_cnt_q < on_cyc);
    end
    else
    begin
        // two-wire: fixed on-bursts only while enable is high
        if (!en_s2_q)
        begin
            burst_cnt_q <= 10'h000;
            power_xfer_q <= 1'b0;
        end
        else
        begin
            if (burst_cnt_q == `BURST_PERIOD_CYC - 1)
                burst_cnt_q <= 10'h000;
            else
                burst_cnt_q <= burst_cnt_q + 10'h001;
            power_xfer_q <= (burst_cnt_q < `TWO_WIRE_ON_CYC);
        end
    end
end

// one-shot pulse and retrigger arming
always @(posedge clk)
begin
    if (!rst_n)
    begin
        en_prev_q <= 1'b0;
        armed_q <= 1'b1;
        pulse_cnt_q <= 6'h00;
    end
    else
    begin
        en_prev_q <= en_s2_q;
        if (!en_s2_q)
            armed_q <= 1'b1;
        if (pulse_cnt_q != 6'h00)
            pulse_cnt_q <= pulse_cnt_q - 6'h01;
        else if (enable_rise && armed_q && oneshot_q && rdy_s2_q)
        begin
            pulse_cnt_q <= pulse_len[5:0];
            armed_q <= 1'b0;
        end
    end
end

// transmit: enable state, or the one-shot pulse in one-shot mode, gated onto the carrier
always @(posedge clk)
begin
    if (!rst_n)
        tx_data_q <= 1'b0;
    else
        tx_data_q <= carrier & (oneshot_q ? (pulse_cnt_q != 6'h00) : en_s2_q);
end

// receive: carrier activity in a recent window means enable high
always @(posedge clk)
begin
    if (!rst_n)
    begin
        rx_cnt_q <= 8'h00;
        rx_en_q <= 1'b0;
    end
    else if (tx_data_q)
    begin
        rx_cnt_q <= `RX_HOLD_CYC;
        rx_en_q <= 1'b1;
    end
    else if (rx_cnt_q != 8'h00)
        rx_cnt_q <= rx_cnt_q - 8'h01;
    else
        rx_en_q <= 1'b0;
end

always @*
begin
    drive_d = rx_en_q && rdy_s2_q;
    if (uv_s2_q)
        drive_d = 1'b0;
    if (!three_wire_q && !en_s2_q)
        drive_d = 1'b0;
    if (state_q != ST_RUN)
        drive_d = 1'b0;
end

always @(posedge clk)
begin
    if (!rst_n)
        gate_drive_q <= 1'b0;
    else
        gate_drive_q <= drive_d;
end

endmodule
`default_nettype wire

// >>> dv/switch_ctrl_properties.sv
/* assertion checker for switch_ctrl, watching its ports only.
   assumes a 20 MHz clock, so one burst period is 500 cycles. */
`timescale 1ns/1ps
`default_nettype none
module switch_ctrl_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host side and rail status
    input wire logic switch_enable,
    input wire logic oneshot_select,
    input wire logic rails_ready,
    input wire logic rails_uvlo,
    // outputs
    input wire logic power_xfer_q,
    input wire logic tx_data_q,
    input wire logic gate_drive_q,
    input wire logic three_wire_q,
    input wire logic [2:0] level_q
);
    logic [9:0] on_q;
    logic [9:0] per_q;
    logic [7:0] hi_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // run lengths of burst, burst period and drive pulse
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            on_q <= 10'h000;
            per_q <= 10'h000;
            hi_q <= 8'h00;
        end
        else
        begin
            on_q <= power_xfer_q ? on_q + 10'h001 : 10'h000;
            per_q <= $rose(power_xfer_q) ? 10'h001 : per_q + 10'h001;
            hi_q <= gate_drive_q ? hi_q + 8'h01 : 8'h00;
        end
    end
    AST_UVLO_LOW: assert property (rails_uvlo [*5] |-> !gate_drive_q)
        else $error("drive high under rail undervoltage");
    AST_RAILS_GATE: assert property (!rails_ready [*4] |-> !gate_drive_q)
        else $error("drive high before rails ready");
    AST_BURST_ON: assert property ($fell(power_xfer_q) && three_wire_q |->
        on_q == {7'h00, level_q} * 10'h042) else $error("burst on-time wrong");
    AST_BURST_PERIOD: assert property ($rose(power_xfer_q) && three_wire_q &&
        per_q > 10'h00A |-> per_q == 10'h1F4) else $error("burst period wrong");
    AST_POWER_ALWAYS: assert property (three_wire_q |-> ##[0:440] power_xfer_q)
        else $error("no power transfer in three-wire mode");
    AST_TWO_WIRE_OFF: assert property ((!three_wire_q && !switch_enable) [*6] |->
        !gate_drive_q && !power_xfer_q) else $error("two-wire activity with enable low");
    AST_STRAPS_HELD: assert property ($past(rst_n) && $past(rst_n, 2) |->
        $stable(three_wire_q) && $stable(level_q)) else $error("captured straps changed");
    AST_FOLLOW_RISE: assert property (three_wire_q && !oneshot_select && rails_ready &&
        !rails_uvlo && $rose(switch_enable) |-> ##[2:20] gate_drive_q)
        else $error("drive did not follow enable");
    AST_CARRIER_GATED: assert property (!switch_enable [*4] |-> !tx_data_q)
        else $error("carrier sent with enable low");
    AST_ONESHOT_LEN: assert property ($fell(gate_drive_q) && three_wire_q && oneshot_select
        |-> hi_q >= 8'h32 && hi_q <= 8'h5A) else $error("one-shot pulse length wrong");
endmodule
`default_nettype wire

// >>> dv/enable_host.sv
/* host controller model driving the switch enable pin.
   assumes the caller waits for each hold to finish. */
`timescale 1ns/1ps
`default_nettype none
module enable_host (
    // clock
    input wire logic clk,
    // enable pin
    output var logic switch_enable
);
    initial switch_enable = 1'b0;
    // each level is kept at least 100 cycles (5 us)
    task automatic hold(input logic lvl, input int cyc);
    begin
        @(posedge clk);
        #2 switch_enable = lvl;
        repeat (cyc > 100 ? cyc : 100) @(posedge clk);
        #2;
    end
    endtask
endmodule
`default_nettype wire

// >>> dv/test_isolated_switch_enable_and_burst_ctrl.sv
/* self-checking bench for switch_ctrl with a host model on the enable pin.
   assumes a 20 MHz clock; rails report ready unless a test says otherwise. */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_isolated_switch_enable_and_burst_ctrl;
    logic clk = 1'b0, rst_n = 1'b0, osel = 1'b0, tw = 1'b1, rdy = 1'b1, uv = 1'b0;
    logic gd_d = 1'b0;
    logic [2:0] lvl = 3'h0;
    wire en, px, tx, gd, twq;
    wire [2:0] lq;
    // on-cycles per power step: two fifteenths of a 500-cycle period, truncated
    localparam int BURST_UNIT = 66;
    // two-wire burst length: 3.3 us at 50 ns
    localparam int TWO_WIRE_ON = 66;
    int n_fail = 0, num_checks = 0, cyc = 0, rises = 0, n_on = 0;
    // rows: mode strap, level code, expected captured level
    logic [6:0] rows [9] = '{7'h41, 7'h49, 7'h52, 7'h5B, 7'h64, 7'h6D, 7'h76, 7'h7F, 7'h1B};
    enable_host host (.clk(clk), .switch_enable(en));
    switch_ctrl dut (.clk(clk), .rst_n(rst_n), .switch_enable(en), .oneshot_select(osel),
        .three_wire_detect(tw), .power_level_select(lvl), .rails_ready(rdy),
        .rails_uvlo(uv), .power_xfer_q(px), .tx_data_q(tx), .gate_drive_q(gd),
        .three_wire_q(twq), .level_q(lq));
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        gd_d <= gd;
        cyc++;
        if (gd && !gd_d)
            rises++;
        if (px)
            n_on++;
        if (cyc > 15000)
        begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic restart(input logic t, input logic [2:0] c);
    begin
        @(posedge clk);
        #2 rst_n = 1'b0;
        tw = t;
        lvl = c;
        repeat (4) @(posedge clk);
        #2 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #2;
    end
    endtask
    task automatic report_and_stop;
    begin
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    initial
    begin
        foreach (rows[i])
        begin
            restart(rows[i][6], rows[i][5:3]);
            lvl = 3'h5;
            `CHECK(twq, rows[i][6])
            host.hold(1'b1, 120);
            `CHECK(gd, 1'b1)
            host.hold(1'b0, 500);
            `CHECK(gd, 1'b0)
            `CHECK(tx, 1'b0)
            // one whole burst period with enable low
            n_on = 0;
            repeat (500) @(posedge clk);
            #2;
            `CHECK(n_on, rows[i][6] ? rows[i][2:0] * BURST_UNIT : 0)
            `CHECK(lq, rows[i][2:0])
            $display("row %0d done", i);
        end
        restart(1'b1, 3'h7);
        host.hold(1'b1, 120);
        `CHECK(gd, 1'b1)
        uv = 1'b1;
        repeat (10) @(posedge clk);
        #2;
        `CHECK(gd, 1'b0)
        uv = 1'b0;
        host.hold(1'b0, 100);
        $display("undervoltage test done");
        osel = 1'b1;
        restart(1'b1, 3'h7);
        rises = 0;
        host.hold(1'b1, 300);
        `CHECK(gd, 1'b0)
        `CHECK(rises, 32'h1)
        host.hold(1'b0, 100);
        host.hold(1'b1, 300);
        `CHECK(rises, 32'h2)
        host.hold(1'b0, 100);
        $display("one-shot test done");
        // two-wire with one-shot strap: rails gate the drive, no pulse shaping
        restart(1'b0, 3'h3);
        rdy = 1'b0;
        n_on = 0;
        host.hold(1'b1, 120);
        `CHECK(gd, 1'b0)
        `CHECK(n_on, TWO_WIRE_ON)
        rdy = 1'b1;
        repeat (40) @(posedge clk);
        #2;
        `CHECK(gd, 1'b1)
        host.hold(1'b0, 100);
        `CHECK(gd, 1'b0)
        $display("two-wire rail test done");
        report_and_stop();
    end
endmodule
bind switch_ctrl switch_ctrl_properties chk (
    .clk(clk),
    .rst_n(rst_n),
    .switch_enable(switch_enable),
    .oneshot_select(oneshot_select),
    .rails_ready(rails_ready),
    .rails_uvlo(rails_uvlo),
    .power_xfer_q(power_xfer_q),
    .tx_data_q(tx_data_q),
    .gate_drive_q(gate_drive_q),
    .three_wire_q(three_wire_q),
    .level_q(level_q)
);
`default_nettype wire
